/* File: logic/rsm_pkg.sv */
/*
 * rsm_pkg: register map, field positions, reset values and timing counts
 * of the supply status monitor.
 * Assumes a 10 MHz ref_clk and a 32-bit APB register bus.
 */
`default_nettype none

package rsm_pkg;

    // ==========================================================
    // timing
    localparam int REF_CLK_MHZ = 10;
    localparam int OSC_HALT_NS = 100000;
    localparam int OSC_HALT_CYCLES = OSC_HALT_NS * REF_CLK_MHZ / 1000;
    localparam int SAMPLE_WIN_US = 7800;
    localparam int SAMPLE_WIN_CYCLES = SAMPLE_WIN_US * REF_CLK_MHZ;
    localparam int RELEASE_DELAY_US = 100000;
    localparam int RELEASE_DELAY_CYCLES = RELEASE_DELAY_US * REF_CLK_MHZ;
    localparam logic [14:0] OSC_EDGES_PER_SEC_M1 = 15'h7FFF;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_ADJ = 8'h07;
    localparam logic [7:0] IDX_CTRL1 = 8'h0E;
    localparam logic [7:0] IDX_CTRL2 = 8'h0F;
    localparam logic [7:0] IDX_STATUS = 8'h10;

    // ==========================================================
    // control register 2 fields
    localparam int CTRL2_SUPPLY_LOW_BIT = 6;
    localparam int CTRL2_OSC_STOP_BIT = 5;
    localparam int CTRL2_POWER_ON_BIT = 4;

    // status register fields
    localparam int STAT_POR_BIT = 0;
    localparam int STAT_HALT_BIT = 1;
    localparam int STAT_MAIN_UP_BIT = 2;
    localparam int STAT_SAMPLE_BIT = 3;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] ADJ_RST = 8'h00;

    // comparator results from the analog side
    typedef struct packed {
        logic internal_supply_below;
        logic main_at_or_below_fall;
        logic main_above_rise;
    } rsm_supply_in_t;

    typedef enum logic [1:0] {
        MS_DOWN,
        MS_DELAY,
        MS_UP
    } rsm_main_state_t;

endpackage : rsm_pkg

`default_nettype wire

/* File: logic/rsm_supply_monitor.sv */
/*
 * rsm_supply_monitor: power-on reset, oscillator halt sensing, sampled
 * backup supply check and main supply reset output, APB register slave.
 * Assumes all inputs synchronous to ref_clk; osc_clk_in is the crystal
 * clock seen as a level, ref_clk being the independent reference.
 */
// Design decisions made here: the APB slave port and the address map.
`default_nettype none

// How it works
// - supply rise from zero resets both control registers and the adjust register
// - internal power-on reset holds until crystal oscillator edges are seen
// - register bus refused while power-on reset active; host must wait
// - oscillator-stop flag sets whenever the crystal clock halts
// - oscillator-stop flag holds until zero written; writing one does nothing
// - supply-low flag is set whenever power-on flag becomes one
// - after supply collapse power-on, oscillator-stop and supply-low all read one
// - backup supply sampled once per second for a 7.8 ms window
// - sampling stops while the supply-low flag is one
// - supply-low flag readable at bit 6 of control register 2, index Fh
// - one threshold for falling and rising backup supply, no hysteresis
// - main supply monitor works continuously, never sampled
// - main supply at or below fall threshold: reset low, switch open
// - main supply above rise threshold: switch closes, reset releases after delay
// - release delay counts from oscillator start if oscillator is halted
// - control register 2 holds supply-low beside interrupt flags in bits 2 to 0; this block reads bits 3 to 0 as zero
module rsm_supply_monitor #(
    parameter int SAMPLE_CYCLES = rsm_pkg::SAMPLE_WIN_CYCLES,
    parameter int RELEASE_CYCLES = rsm_pkg::RELEASE_DELAY_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_clk_in,
    input wire rsm_pkg::rsm_supply_in_t supply_in,
    output logic supply_sample_en,
    output logic cpu_reset_out_n,
    output logic main_supply_switch,
    output logic por_active
);
    import rsm_pkg::*;

    // ==========================================================
    // state
    logic por_ff;
    logic osc_prev_ff;
    logic osc_halted_ff;
    logic [15:0] halt_cnt_ff;
    logic [14:0] sec_cnt_ff;
    logic [19:0] samp_cnt_ff;
    logic sample_ff;
    logic [23:0] rel_cnt_ff;
    rsm_main_state_t main_ff;
    logic rst_out_n_ff;
    logic switch_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] adj_ff;
    logic power_on_flag_ff;
    logic osc_stop_flag_ff;
    logic supply_low_flag_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // ==========================================================
    // oscillator edge and halt sensing
    wire osc_edge = osc_clk_in != osc_prev_ff;
    wire osc_rise = osc_clk_in & ~osc_prev_ff;
    wire halt_evt = ~osc_edge & ~osc_halted_ff
                    & (halt_cnt_ff == 16'(OSC_HALT_CYCLES - 1));
    wire sec_tick = osc_rise & (sec_cnt_ff == OSC_EDGES_PER_SEC_M1);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_prev_ff <= 1'b0;
            halt_cnt_ff <= 16'h0000;
            osc_halted_ff <= 1'b1;
            sec_cnt_ff <= 15'h0000;
        end else begin
            osc_prev_ff <= osc_clk_in;
            if (osc_edge) begin
                halt_cnt_ff <= 16'h0000;
                osc_halted_ff <= 1'b0;
            end else if (halt_evt) begin
                osc_halted_ff <= 1'b1;
            end else if (!osc_halted_ff) begin
                halt_cnt_ff <= halt_cnt_ff + 16'h0001;
            end
            if (osc_rise) begin
                sec_cnt_ff <= sec_cnt_ff + 15'h0001;
            end
        end
    end

    // internal reset lasts until the crystal is seen running
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            por_ff <= 1'b1;
        end else if (!osc_halted_ff) begin
            por_ff <= 1'b0;
        end
    end

    // ==========================================================
    // backup supply sampling, single comparator so no hysteresis
    wire samp_done = samp_cnt_ff == 20'(SAMPLE_CYCLES - 1);
    wire low_evt = sample_ff & supply_in.internal_supply_below;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_ff <= 1'b0;
            samp_cnt_ff <= 20'h00000;
        end else if (supply_low_flag_ff || low_evt) begin
            sample_ff <= 1'b0;
            samp_cnt_ff <= 20'h00000;
        end else if (sample_ff) begin
            sample_ff <= ~samp_done;
            samp_cnt_ff <= samp_done ? 20'h00000 : samp_cnt_ff + 20'h00001;
        end else if (sec_tick) begin
            sample_ff <= 1'b1;
        end
    end

    // ==========================================================
    // main supply monitor, evaluated every cycle
    wire rel_done = rel_cnt_ff == 24'(RELEASE_CYCLES - 1);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_ff <= MS_DOWN;
            rst_out_n_ff <= 1'b0;
            switch_ff <= 1'b0;
            rel_cnt_ff <= 24'h000000;
        end else if (supply_in.main_at_or_below_fall) begin
            main_ff <= MS_DOWN;
            rst_out_n_ff <= 1'b0;
            switch_ff <= 1'b0;
            rel_cnt_ff <= 24'h000000;
        end else begin
            case (main_ff)
                MS_DOWN: begin
                    if (supply_in.main_above_rise) begin
                        main_ff <= MS_DELAY;
                        switch_ff <= 1'b1;
                    end
                end
                MS_DELAY: begin
                    // delay only advances on a running crystal
                    if (!osc_halted_ff) begin
                        if (rel_done) begin
                            main_ff <= MS_UP;
                            rst_out_n_ff <= 1'b1;
                        end else begin
                            rel_cnt_ff <= rel_cnt_ff + 24'h000001;
                        end
                    end
                end
                MS_UP: begin
                    main_ff <= MS_UP;
                end
                default: begin
                    main_ff <= MS_DOWN;
                end
            endcase
        end
    end

    // ==========================================================
    // apb decode; one wait state, answer on second access cycle
    wire access = psel & penable & ~pready_ff;
    wire [7:0] idx = paddr[9:2];
    wire in_range = paddr[31:10] == 22'h000000;
    wire hit_adj = in_range & (idx == IDX_ADJ);
    wire hit_ctrl1 = in_range & (idx == IDX_CTRL1);
    wire hit_ctrl2 = in_range & (idx == IDX_CTRL2);
    wire hit_stat = in_range & (idx == IDX_STATUS);
    wire mapped = hit_adj | hit_ctrl1 | hit_ctrl2 | (hit_stat & ~pwrite);
    wire refuse = por_ff | ~mapped;
    wire wr_ok = access & pwrite & ~refuse;
    wire wr_ctrl2 = wr_ok & hit_ctrl2;
    wire clr_osc_stop = wr_ctrl2 & ~pwdata[CTRL2_OSC_STOP_BIT];
    wire clr_power_on = wr_ctrl2 & ~pwdata[CTRL2_POWER_ON_BIT];
    wire clr_supply_low = wr_ctrl2 & ~pwdata[CTRL2_SUPPLY_LOW_BIT];

    // interrupt flags of bits 2 to 0 are outside this block and read zero
    wire [7:0] ctrl2_rd = {1'b0, supply_low_flag_ff, osc_stop_flag_ff,
                           power_on_flag_ff, 4'h0};
    wire [7:0] stat_rd = {4'h0, sample_ff, main_ff == MS_UP,
                          osc_halted_ff, por_ff};
    wire [7:0] rd_sel = hit_adj ? adj_ff :
                        hit_ctrl1 ? ctrl1_ff :
                        hit_ctrl2 ? ctrl2_rd :
                        hit_stat ? stat_rd : 8'h00;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access & refuse;
            prdata_ff <= (access & ~pwrite & ~refuse) ? {24'h000000, rd_sel}
                                                      : 32'h00000000;
        end
    end

    // registers cleared by the system reset sys_rst
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_ff <= CTRL1_RST;
            adj_ff <= ADJ_RST;
        end else begin
            if (wr_ok && hit_ctrl1) begin
                ctrl1_ff <= pwdata[7:0];
            end
            if (wr_ok && hit_adj) begin
                adj_ff <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // flags: set on reset, zero write clears, set wins over clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_on_flag_ff <= 1'b1;
            osc_stop_flag_ff <= 1'b1;
            supply_low_flag_ff <= 1'b1;
        end else begin
            power_on_flag_ff <= power_on_flag_ff & ~clr_power_on;
            osc_stop_flag_ff <= halt_evt | (osc_stop_flag_ff & ~clr_osc_stop);
            supply_low_flag_ff <= low_evt | (supply_low_flag_ff & ~clr_supply_low);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign supply_sample_en = sample_ff;
    assign cpu_reset_out_n = rst_out_n_ff;
    assign main_supply_switch = switch_ff;
    assign por_active = por_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_POR_REFUSES: assert property (por_ff && access |=> pslverr_ff)
        else $error("bus access answered without error during power-on reset");
    AST_POR_UNTIL_OSC: assert property (osc_halted_ff && por_ff |=> por_ff)
        else $error("power-on reset ended before oscillator start");
    AST_HALT_SETS_FLAG: assert property (halt_evt |=> osc_stop_flag_ff && osc_halted_ff)
        else $error("halt not recorded in oscillator-stop flag");
    AST_OSC_STOP_HOLDS: assert property (osc_stop_flag_ff && !clr_osc_stop
                                         |=> osc_stop_flag_ff)
        else $error("oscillator-stop flag dropped without a zero write");
    AST_ONE_WRITE_NO_SET: assert property (!osc_stop_flag_ff && !halt_evt
                                           |=> !osc_stop_flag_ff)
        else $error("oscillator-stop flag set without a halt");
    AST_SET_WINS: assert property (halt_evt && clr_osc_stop |=> osc_stop_flag_ff)
        else $error("simultaneous clear lost a halt event");
    AST_POR_FLAGS: assert property (por_ff |-> power_on_flag_ff && supply_low_flag_ff
                                    && osc_stop_flag_ff)
        else $error("flags not all set during power-on reset");
    AST_NO_SAMPLE_WHEN_LOW: assert property (supply_low_flag_ff |=> !sample_ff)
        else $error("sampling continued with supply-low flag set");
    AST_MAIN_FALL: assert property (supply_in.main_at_or_below_fall
                                    |=> !rst_out_n_ff && !switch_ff)
        else $error("reset not asserted on main supply fall");
    AST_RELEASE_AFTER_DELAY: assert property ($rose(rst_out_n_ff)
                                              |-> $past(rel_done) && switch_ff)
        else $error("reset released before delay elapsed");
    AST_DELAY_FROZEN_HALTED: assert property (osc_halted_ff && main_ff == MS_DELAY
                                              |=> $stable(rel_cnt_ff))
        else $error("release delay advanced on a halted oscillator");
    AST_LOW_ENDS_WINDOW: assert property (low_evt |=> supply_low_flag_ff && !sample_ff)
        else $error("supply low in window not recorded");
    AST_SWITCH_CLOSES: assert property (main_ff == MS_DOWN && supply_in.main_above_rise
        && !supply_in.main_at_or_below_fall |=> switch_ff)
        else $error("supply switch not closed on main supply rise");

    COV_POR_END: cover property ($fell(por_ff));
    COV_SAMPLE_LOW: cover property (low_evt ##1 supply_low_flag_ff);
    COV_RELEASE: cover property ($rose(rst_out_n_ff));
    COV_CLEAR_FLAG: cover property (clr_supply_low ##1 !supply_low_flag_ff);
    COV_SET_WINS: cover property (halt_evt && clr_osc_stop);

endmodule : rsm_supply_monitor

`default_nettype wire

/* File: tb/rsm_host_model.sv */
/* rsm_host_model: host side APB master of the supply monitor.
   assumes ref_clk is shared with the monitor and the bench calls xfer. */
`default_nettype none
module rsm_host_model import rsm_pkg::*; (
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // ==========================================
    // one transfer; early calls only to see a refusal
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // no cycle count assumed; only the bench watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
    // zero write clears the supply-low, oscillator-stop and power-on flags
    task automatic clear_flags();
        logic [31:0] rd;
        logic err;
        xfer(1'h1, {22'h0, IDX_CTRL2, 2'h0}, 32'h0, rd, err);
    endtask : clear_flags
endmodule : rsm_host_model
`default_nettype wire

/* File: tb/test_rsm_supply_monitor.sv */
/* test_rsm_supply_monitor: directed bench of the supply monitor.
   assumes the monitor's own assertions; short counts set by parameters. */
`default_nettype none
module test_rsm_supply_monitor import rsm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 20;
    localparam int RC = 30;
    localparam logic [31:0] A_ADJ = {22'h0, IDX_ADJ, 2'h0};
    localparam logic [31:0] A_C1 = {22'h0, IDX_CTRL1, 2'h0};
    localparam logic [31:0] A_C2 = {22'h0, IDX_CTRL2, 2'h0};
    localparam logic [31:0] A_ST = {22'h0, IDX_STATUS, 2'h0};
    localparam logic [31:0] F_LOW = 32'h1 << CTRL2_SUPPLY_LOW_BIT;
    localparam logic [31:0] F_OSC = 32'h1 << CTRL2_OSC_STOP_BIT;
    localparam logic [31:0] F_ALL = F_LOW | F_OSC | (32'h1 << CTRL2_POWER_ON_BIT);
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, osc_clk_in;
    logic supply_sample_en, cpu_reset_out_n, main_supply_switch, por_active, osc_run;
    logic [31:0] paddr, pwdata, prdata;
    rsm_supply_in_t supply_in;
    int errors, cmp_count, cycles, n;
    rsm_supply_monitor #(.SAMPLE_CYCLES(SC), .RELEASE_CYCLES(RC)) uut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_clk_in(osc_clk_in), .supply_in(supply_in), .supply_sample_en(supply_sample_en),
        .cpu_reset_out_n(cpu_reset_out_n), .main_supply_switch(main_supply_switch),
        .por_active(por_active));
    rsm_host_model u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // ==========================================
    // clocks and watchdog
    always #50 ref_clk = ~ref_clk;
    // crystal toggles every cycle so a second stays short
    always @(posedge ref_clk) begin
        if (osc_run) begin
            osc_clk_in <= ~osc_clk_in;
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            stop_test();
        end
    end
    // ==========================================
    // compares and bus helpers
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] wd,
        input logic [31:0] xd, input logic xe);
        logic [31:0] d;
        logic e;
        u_host.xfer(w, a, wd, d, e);
        check_bit(e, xe);
        if (!w) begin
            check_word(d, xd);
        end
    endtask : acc
    task automatic wait_val(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
        if (s !== v) begin
            errors++;
            $display("FAIL %0t wait limit reached", $time);
        end
    endtask : wait_val
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // ==========================================
    // main sequence
    initial begin
        {ref_clk, osc_clk_in, osc_run, errors, cmp_count, cycles} = '0;
        sys_rst = 1'h1;
        supply_in = '0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        #1 check_bit(por_active, 1'h1);
        acc(1'h0, A_C2, 32'h0, 32'h0, 1'h1);
        osc_run <= 1'h1;
        wait_val(por_active, 1'h0, 100);
        check_bit(por_active, 1'h0);
        $display("test power-on done");
        acc(1'h0, A_C2, 32'h0, F_ALL, 1'h0);
        acc(1'h0, A_C1, 32'h0, {24'h0, CTRL1_RST}, 1'h0);
        acc(1'h0, A_ADJ, 32'h0, {24'h0, ADJ_RST}, 1'h0);
        acc(1'h1, A_C2, 32'h0000_00FF, 32'h0, 1'h0);
        acc(1'h0, A_C2, 32'h0, F_ALL, 1'h0);
        acc(1'h0, 32'h0000_0000, 32'h0, 32'h0, 1'h1);
        acc(1'h1, A_ST, 32'h0000_0001, 32'h0, 1'h1);
        u_host.clear_flags();
        acc(1'h0, A_C2, 32'h0, 32'h0, 1'h0);
        $display("test flags done");
        // low outside a window must not reach the flag
        supply_in.internal_supply_below <= 1'h1;
        repeat (5) @(posedge ref_clk);
        acc(1'h0, A_C2, 32'h0, 32'h0, 1'h0);
        supply_in.internal_supply_below <= 1'h0;
        // one window per second: wait a full second tick
        wait_val(supply_sample_en, 1'h1, 70000);
        n = 0;
        while (supply_sample_en === 1'h1 && n < 100) begin
            @(posedge ref_clk);
            n++;
            // low seen on the window's last edge, so its length stays SC
            if (n == SC - 2) begin
                supply_in.internal_supply_below <= 1'h1;
            end
        end
        check_word(32'(n), 32'(SC));
        acc(1'h0, A_C2, 32'h0, F_LOW, 1'h0);
        supply_in.internal_supply_below <= 1'h0;
        u_host.clear_flags();
        $display("test sampling done");
        supply_in.main_above_rise <= 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 check_bit(main_supply_switch, 1'h1);
        repeat (25) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h0);
        repeat (10) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h1);
        supply_in <= 3'h2;
        repeat (2) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h0);
        check_bit(main_supply_switch, 1'h0);
        supply_in <= 3'h0;
        $display("test main supply done");
        osc_run <= 1'h0;
        // zero write lands on the very edge that declares the halt
        repeat (OSC_HALT_CYCLES - 2) @(posedge ref_clk);
        acc(1'h1, A_C2, 32'h0, 32'h0, 1'h0);
        acc(1'h0, A_C2, 32'h0, F_OSC, 1'h0);
        supply_in.main_above_rise <= 1'h1;
        repeat (50) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h0);
        @(posedge ref_clk);
        osc_run <= 1'h1;
        repeat (25) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h0);
        repeat (15) @(posedge ref_clk);
        #1 check_bit(cpu_reset_out_n, 1'h1);
        acc(1'h0, A_C2, 32'h0, F_OSC, 1'h0);
        u_host.clear_flags();
        acc(1'h0, A_C2, 32'h0, 32'h0, 1'h0);
        $display("test halt done");
        stop_test();
    end
endmodule : test_rsm_supply_monitor
`default_nettype wire
